// File: design/gpc3_params.svh
// Offsets, field positions, reset values and counts of the pin three control block
// ================================================================
`ifndef GPC3_PARAMS_SVH
`define GPC3_PARAMS_SVH
// ================================================================
// Register indices; byte address is four times the index
`define GPC3_CTRL_IDX 18'h0403A
`define GPC3_STAT_IDX 18'h04040
`define GPC3_MASK_IDX 18'h04041
`define GPC3_DATA_IDX 18'h04042
// ================================================================
// Control fields
`define GPC3_DIR_BIT 15
`define GPC3_PULL_HI 14
`define GPC3_PULL_LO 13
`define GPC3_MODE_BIT 12
`define GPC3_DOM_BIT 11
`define GPC3_POL_BIT 10
`define GPC3_OD_BIT 9
`define GPC3_ENA_BIT 7
`define GPC3_FN_HI 3
`define GPC3_FN_LO 0
// Writable bits of the control word
`define GPC3_CTRL_WMASK 16'hFE8F
`define GPC3_CTRL_RST 16'hA400
// Pull codes
`define GPC3_PULL_DOWN 2'h1
`define GPC3_PULL_UP 2'h2
// ================================================================
// Status, mask and data fields
`define GPC3_EDGE_BIT 0
`define GPC3_OUT_BIT 0
`define GPC3_LVL_BIT 1
// Long debounce length in core cycles
`define GPC3_LONG_DB 1024
`endif

// File: design/gpc3_pkg.sv
// Types shared by the pin three control block
package gpc3_pkg;
  // Function field
  typedef logic [3:0] gpc3_fn_t;
  // Output function codes
  typedef enum logic [3:0] {
    GPC3_OUT_REG = 4'h0,
    GPC3_OUT_OSC = 4'h1,
    GPC3_OUT_ON = 4'h2,
    GPC3_OUT_SLEEP = 4'h3,
    GPC3_OUT_CHG = 4'h4,
    GPC3_OUT_DONE1 = 4'h8,
    GPC3_OUT_DONE2 = 4'h9,
    GPC3_OUT_EXT1 = 4'hA,
    GPC3_OUT_EXT2 = 4'hB,
    GPC3_OUT_SUPPLY_GOOD = 4'hC,
    GPC3_OUT_PGOOD = 4'hD,
    GPC3_OUT_CLK2M = 4'hE,
    GPC3_OUT_AUXRST = 4'hF
  } gpc3_out_fn_e;
endpackage : gpc3_pkg

// File: design/gpc3_top.sv
// Pin three control: register, pin driver, input roles and pin interrupt
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "gpc3_params.svh"

module gpc3_top
  import gpc3_pkg::*;
#(
  parameter int LONG_DB = `GPC3_LONG_DB
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [19:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pad
  input wire logic pad_in,
  output logic pad_out,
  output logic pad_oe_n,
  output logic pull_up_en,
  output logic pull_down_en,
  output logic supply_sel,
  // Input roles, one bit per input code
  output logic [15:0] role_level,
  // Output sources from device logic
  input wire logic osc_32k_clk,
  input wire logic on_state,
  input wire logic sleep_state,
  input wire logic power_state_change,
  input wire logic dvs_done_one,
  input wire logic dvs_done_two,
  input wire logic ext_power_en_one,
  input wire logic ext_power_en_two,
  input wire logic system_supply_good,
  input wire logic converter_power_good,
  input wire logic ext_power_clk_2m,
  input wire logic aux_reset,
  // Interrupt
  output logic irq
);

  // ================================================================
  // Helpers

  // Map between pad level and logical level
  function automatic logic pol_apply(input logic lvl, input logic pol);
    pol_apply = pol ? lvl : ~lvl;
  endfunction : pol_apply

  // Codes that ask for the long debounce
  function automatic logic long_db(input gpc3_fn_t fn);
    long_db = (fn == 4'h0) || (fn == 4'h4) ||
              (fn == 4'hE) || (fn == 4'hF);
  endfunction : long_db

  // ================================================================
  // Register state

  logic [15:0] ctrl; // Control word
  logic edge_stat; // Sticky edge flag
  logic edge_mask; // Interrupt enable
  logic out_level; // Level for output code 0

  // Field views
  logic f_dir;
  logic [1:0] f_pull;
  logic f_mode;
  logic f_pol;
  logic f_od;
  logic f_ena;
  gpc3_fn_t f_fn;
  assign f_dir = ctrl[`GPC3_DIR_BIT];
  assign f_pull = ctrl[`GPC3_PULL_HI:`GPC3_PULL_LO];
  assign f_mode = ctrl[`GPC3_MODE_BIT];
  assign f_pol = ctrl[`GPC3_POL_BIT];
  assign f_od = ctrl[`GPC3_OD_BIT];
  assign f_ena = ctrl[`GPC3_ENA_BIT];
  assign f_fn = ctrl[`GPC3_FN_HI:`GPC3_FN_LO];

  // ================================================================
  // APB decode

  logic [17:0] idx; // Word index
  logic acc; // Access phase
  logic done; // Completing edge
  logic wr_done;
  logic rd_done;
  logic mapped;
  assign idx = paddr[19:2];
  assign acc = psel && penable;
  assign done = acc && pready;
  assign wr_done = done && pwrite;
  assign rd_done = done && !pwrite;
  assign mapped = (idx == `GPC3_CTRL_IDX) || (idx == `GPC3_STAT_IDX) ||
                  (idx == `GPC3_MASK_IDX) || (idx == `GPC3_DATA_IDX);

  // Read mux
  logic [31:0] next_prdata;
  logic in_lvl; // Debounced logical level
  always_comb begin
    next_prdata = 32'h0000_0000;
    case (idx)
      `GPC3_CTRL_IDX: next_prdata = {16'h0000, ctrl};
      `GPC3_STAT_IDX: next_prdata = {31'h0000_0000, edge_stat};
      `GPC3_MASK_IDX: next_prdata = {31'h0000_0000, edge_mask};
      `GPC3_DATA_IDX: next_prdata = {30'h0000_0000, in_lvl, out_level};
      default: next_prdata = 32'h0000_0000;
    endcase
  end

  // One wait state keeps prdata and pready straight from flops
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= acc && !pready;
      prdata <= (acc && !pready && !pwrite) ? next_prdata : 32'h0000_0000;
      pslverr <= acc && !pready && !mapped;
    end
  end

  // ================================================================
  // Control word; reserved bits stay zero
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ctrl <= `GPC3_CTRL_RST;
    end else if (wr_done && idx == `GPC3_CTRL_IDX) begin
      ctrl <= pwdata[15:0] & `GPC3_CTRL_WMASK;
    end
  end

  // Mask and output level registers
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      edge_mask <= 1'b0;
      out_level <= 1'b0;
    end else begin
      if (wr_done && idx == `GPC3_MASK_IDX) begin
        edge_mask <= pwdata[`GPC3_EDGE_BIT];
      end
      if (wr_done && idx == `GPC3_DATA_IDX) begin
        out_level <= pwdata[`GPC3_OUT_BIT];
      end
    end
  end

  // ================================================================
  // Pad input: synchroniser then debounce

  logic sync_a; // First stage, read only by sync_b
  logic sync_b;
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end else begin
      sync_a <= pad_in;
      sync_b <= sync_a;
    end
  end

  // Filtered pad level and its run counter
  logic stable;
  logic [15:0] db_cnt;
  logic db_long;
  assign db_long = long_db(f_fn);

  // Short path accepts at once; long path needs LONG_DB equal samples
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      stable <= 1'b0;
      db_cnt <= 16'h0000;
    end else if (sync_b == stable) begin
      db_cnt <= 16'h0000;
    end else if (!db_long || db_cnt >= 16'(LONG_DB - 1)) begin
      stable <= sync_b;
      db_cnt <= 16'h0000;
    end else begin
      db_cnt <= db_cnt + 16'h0001;
    end
  end

  assign in_lvl = pol_apply(stable, f_pol);

  // Input table is live only for an enabled input pin
  logic in_live;
  assign in_live = f_ena && f_dir;

  // ================================================================
  // Input roles: one bit per code, others low
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      role_level <= 16'h0000;
    end else if (in_live) begin
      // Codes 0..15 select the role bit alike
      role_level <= 16'(in_lvl) << f_fn;
    end else begin
      role_level <= 16'h0000;
    end
  end

  // ================================================================
  // Pin interrupt

  logic stable_q; // Previous filtered level
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      stable_q <= 1'b0;
    end else begin
      stable_q <= stable;
    end
  end

  // Edge of the logical level, chosen by mode
  logic rise_l;
  logic any_e;
  logic edge_hit;
  assign any_e = stable ^ stable_q;
  assign rise_l = any_e && in_lvl;
  assign edge_hit = in_live && (f_mode ? any_e : rise_l);

  // Sticky flag; a new edge beats the read that clears it
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      edge_stat <= 1'b0;
    end else if (edge_hit) begin
      edge_stat <= 1'b1;
    end else if (rd_done && idx == `GPC3_STAT_IDX) begin
      edge_stat <= 1'b0;
    end
  end

  // Level interrupt, one cycle behind the flag
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= edge_stat && edge_mask;
    end
  end

  // ================================================================
  // Output source select
  logic src; // Logical level to drive
  always_comb begin
    src = 1'b0;
    case (f_fn)
      GPC3_OUT_REG: src = out_level;
      GPC3_OUT_OSC: src = osc_32k_clk;
      GPC3_OUT_ON: src = on_state;
      GPC3_OUT_SLEEP: src = sleep_state;
      GPC3_OUT_CHG: src = power_state_change;
      GPC3_OUT_DONE1: src = dvs_done_one;
      GPC3_OUT_DONE2: src = dvs_done_two;
      GPC3_OUT_EXT1: src = ext_power_en_one;
      GPC3_OUT_EXT2: src = ext_power_en_two;
      GPC3_OUT_SUPPLY_GOOD: src = system_supply_good;
      GPC3_OUT_PGOOD: src = converter_power_good;
      GPC3_OUT_CLK2M: src = ext_power_clk_2m;
      GPC3_OUT_AUXRST: src = aux_reset;
      // Reserved codes 5..7 drive inactive
      default: src = 1'b0;
    endcase
  end

  // Pad level after polarity
  logic drv;
  assign drv = pol_apply(src, f_pol);

  // ================================================================
  // Pad driver; open-drain only ever pulls low
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      pad_out <= 1'b0;
      pad_oe_n <= 1'b1;
    end else if (!f_ena || f_dir) begin
      pad_out <= 1'b0;
      pad_oe_n <= 1'b1;
    end else if (f_od) begin
      pad_out <= 1'b0;
      pad_oe_n <= drv;
    end else begin
      pad_out <= drv;
      pad_oe_n <= 1'b0;
    end
  end

  // Pull and supply controls
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      pull_up_en <= 1'b0;
      pull_down_en <= 1'b1;
      supply_sel <= 1'b0;
    end else begin
      // Reserved pull code leaves both resistors off
      pull_up_en <= (f_pull == `GPC3_PULL_UP);
      pull_down_en <= (f_pull == `GPC3_PULL_DOWN);
      supply_sel <= ctrl[`GPC3_DOM_BIT];
    end
  end

  // ================================================================
  // Checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  // Reset value
  ctrl_reset_a: assert property ($rose(resetn) |-> ctrl == 16'hA400)
    else $error("control word wrong after reset");

  // Pull decode
  pull_decode_a: assert property (##1 (pull_up_en == ($past(f_pull) == 2'h2) &&
    pull_down_en == ($past(f_pull) == 2'h1)))
    else $error("pull resistor select wrong");

  // Tri-state while disabled
  tristate_hold_a: assert property (!f_ena |=> pad_oe_n)
    else $error("pin driven while disabled");

  // Open-drain never drives high
  od_no_high_a: assert property (!f_dir && f_ena && f_od |=> !pad_out)
    else $error("open-drain pin drove high");

  // Push-pull follows source with polarity
  cmos_level_a: assert property (!f_dir && f_ena && !f_od && $stable(ctrl)
    |=> !pad_oe_n && pad_out == ($past(f_pol) ? $past(src) : !$past(src)))
    else $error("push-pull level wrong");

  // Single-edge mode ignores the inactive edge
  single_edge_a: assert property (in_live && !f_mode && any_e && !in_lvl && !edge_stat
    && !(rd_done && idx == `GPC3_STAT_IDX) |=> !edge_stat)
    else $error("inactive edge raised the flag");

  // Both-edge mode catches any edge
  both_edge_a: assert property (in_live && f_mode && any_e |=> edge_stat)
    else $error("edge missed in both-edge mode");

  // Role bit follows the selected code
  role_map_a: assert property (in_live && $stable(ctrl) |=>
    role_level == (16'($past(in_lvl)) << $past(f_fn)))
    else $error("input role mapping wrong");

  // Long debounce hides short glitches
  long_db_a: assert property ($changed(stable) && db_long && $past(db_long) |->
    $past(db_cnt) == 16'(LONG_DB - 1))
    else $error("long debounce accepted early");

  // Supply select follows bit 11
  supply_sel_a: assert property (##1 supply_sel == $past(ctrl[`GPC3_DOM_BIT]))
    else $error("supply select wrong");

  // APB answers within one wait state
  apb_answer_a: assert property (acc && !pready |=> pready)
    else $error("APB answer late");

  // Main scenarios
  cov_edge_c: cover property (edge_hit ##1 edge_stat ##1 irq);
  cov_od_c: cover property (!f_dir && f_ena && f_od && !pad_oe_n);
  cov_rdclr_c: cover property (rd_done && idx == `GPC3_STAT_IDX && edge_stat);
  cov_longdb_c: cover property (db_long && $changed(stable));

endmodule : gpc3_top

`default_nettype wire

// File: tb/gpc3_pad_model.sv
// Far-side pad model: external driver, pull resistors and floating line
`timescale 1ns/1ps
`default_nettype none

module gpc3_pad_model (
  // Clock
  input wire logic core_clk,
  // Device side of the pad
  input wire logic pad_out,
  input wire logic pad_oe_n,
  input wire logic pull_up_en,
  input wire logic pull_down_en,
  // Bench commands
  input wire logic ext_drive,
  input wire logic ext_level,
  // Resolved wire level
  output logic pad_in
);
  // Toggle pattern for an undriven line
  logic flip = 1'b0;

  // ====================
  // Floating line must never look stable
  always @(posedge core_clk) begin
    flip <= ~flip;
  end

  // ====================
  // Wire resolution, device driver wins
  always_comb begin
    if (!pad_oe_n) begin
      pad_in = pad_out;
    end else if (ext_drive) begin
      pad_in = ext_level;
    end else if (pull_up_en) begin
      pad_in = 1'b1;
    end else if (pull_down_en) begin
      pad_in = 1'b0;
    end else begin
      pad_in = flip;
    end
  end
endmodule : gpc3_pad_model

`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench for the pin three control block
`timescale 1ns/1ps
`default_nettype none
`include "gpc3_params.svh"

module testbench import gpc3_pkg::*;;
  // ====================
  // Register byte addresses
  localparam logic [19:0] A_CTRL = {`GPC3_CTRL_IDX, 2'b00};
  localparam logic [19:0] A_STAT = {`GPC3_STAT_IDX, 2'b00};
  localparam logic [19:0] A_MASK = {`GPC3_MASK_IDX, 2'b00};
  localparam logic [19:0] A_DATA = {`GPC3_DATA_IDX, 2'b00};
  // Design inputs
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [19:0] paddr = 20'h00000;
  logic [31:0] pwdata = 32'h00000000;
  logic [15:0] src = 16'h0000; // Bit n feeds output code n
  // Design outputs
  logic [31:0] prdata;
  logic pready, pslverr, pad_in, pad_out, pad_oe_n, irq;
  logic pull_up_en, pull_down_en, supply_sel;
  logic [15:0] role_level;
  // Far side commands
  logic ext_drive = 1'b0;
  logic ext_level = 1'b0;
  // Bench state
  int fails = 0;
  int total_checks = 0;
  int md;
  logic [15:0] seed = 16'h005F;
  logic [31:0] q;
  logic e, v;
  logic [3:0] fn;

  // 100 MHz clock
  always #5 core_clk = ~core_clk;

  // ====================
  // Short debounce count keeps the run brief
  gpc3_top #(.LONG_DB(4)) i_gpc3_top (
    .core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pull_up_en(pull_up_en),
    .pull_down_en(pull_down_en), .supply_sel(supply_sel), .role_level(role_level),
    .osc_32k_clk(src[1]), .on_state(src[2]), .sleep_state(src[3]),
    .power_state_change(src[4]), .dvs_done_one(src[8]), .dvs_done_two(src[9]),
    .ext_power_en_one(src[10]), .ext_power_en_two(src[11]), .system_supply_good(src[12]),
    .converter_power_good(src[13]), .ext_power_clk_2m(src[14]), .aux_reset(src[15]),
    .irq(irq)
  );
  gpc3_pad_model i_gpc3_pad_model (
    .core_clk(core_clk), .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pull_up_en(pull_up_en),
    .pull_down_en(pull_down_en), .ext_drive(ext_drive), .ext_level(ext_level),
    .pad_in(pad_in)
  );

  // ====================
  // Compare and count
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // One APB transfer, entered at a rising edge; result in q and e
  // No cycle limit of its own: a missing answer is left to the watchdog
  task automatic apb(input logic wr, input logic [19:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge so the next setup is a fresh assignment
    @(posedge core_clk);
  endtask : apb

  // Random source values
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  // Expected pad level for an output code; reserved codes give logical 0
  function automatic logic exp_out(input logic [3:0] f, input logic [15:0] s, input logic pol);
    logic x;
    x = (f inside {[4'h5:4'h7]}) ? 1'b0 : s[f];
    return x ^ ~pol;
  endfunction : exp_out

  // Pin edge from l0 to l1 under control word c and mask m
  task automatic irq_case(input logic [15:0] c, input logic m, input logic l0,
                          input logic l1, input logic ev);
    apb(1'b1, A_MASK, {31'h0, m});
    apb(1'b1, A_CTRL, {16'h0, c});
    ext_level <= l0;
    repeat (15) @(posedge core_clk);
    // Clear anything raised by the setup itself
    apb(1'b0, A_STAT, 32'h0);
    ext_level <= l1;
    repeat (15) @(posedge core_clk);
    chk("irq", irq, ev & m);
    apb(1'b0, A_STAT, 32'h0);
    chk("status", q, {31'h0, ev});
    repeat (2) @(posedge core_clk);
    chk("irq_clr", irq, 1'b0);
  endtask : irq_case

  // Verdict, reached from the main flow or the watchdog
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up

  // ====================
  // Main sequence
  initial begin
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    apb(1'b0, A_CTRL, 32'h0);
    chk("ctrl_rst", q, 32'h0000A400);
    chk("pad_rst", {pull_down_en, pull_up_en, pad_oe_n, supply_sel, irq}, 5'h14);
    chk("role_rst", role_level, 16'h0000);
    apb(1'b1, A_CTRL, 32'hFFFFFFFF);
    apb(1'b0, A_CTRL, 32'h0);
    chk("ctrl_bits", q, 32'h0000FE8F);
    apb(1'b0, 20'h00000, 32'h0);
    chk("unmapped_err", e, 1'b1);
    chk("unmapped_data", q, 32'h0);
    // Output direction but pin disabled stays released
    apb(1'b1, A_CTRL, 32'h00000400);
    repeat (3) @(posedge core_clk);
    chk("tristate", pad_oe_n, 1'b1);
    // Every pull code, always-on supply
    for (int p = 0; p < 4; p++) begin
      apb(1'b1, A_CTRL, {16'h0, 1'b1, p[1:0], 13'h0800});
      repeat (3) @(posedge core_clk);
      chk("pull", {pull_up_en, pull_down_en, supply_sel}, {p == 2, p == 1, 1'b1});
    end
    // Output codes: true, inverted, open-drain
    for (int k = 0; k < 48; k++) begin
      md = k / 16;
      fn = k[3:0];
      seed = lfsr(seed);
      src <= seed;
      apb(1'b1, A_DATA, {31'h0, seed[0]});
      apb(1'b1, A_CTRL, {16'h0, 5'h0, md != 1, md == 2, 5'h08, fn});
      repeat (3) @(posedge core_clk);
      v = exp_out(fn, seed, md != 1);
      if (md == 2) begin
        chk("od", {pad_oe_n, pad_oe_n | pad_out}, {v, v});
      end else begin
        chk("pad", {pad_oe_n, pad_out}, {1'b0, v});
      end
    end
    // Input codes: one role bit follows the pin
    ext_drive <= 1'b1;
    for (int k = 0; k < 16; k++) begin
      fn = k[3:0];
      ext_level <= 1'b0;
      apb(1'b1, A_CTRL, {16'h0, 12'h848, fn});
      repeat (20) @(posedge core_clk);
      chk("role_lo", role_level, 16'h0000);
      ext_level <= 1'b1;
      // Short codes pass the edge by now, long-debounce codes still hold it back
      repeat (6) @(posedge core_clk);
      v = fn inside {4'h0, 4'h4, 4'hE, 4'hF};
      chk("role_db", role_level, v ? 16'h0000 : 16'h0001 << fn);
      repeat (14) @(posedge core_clk);
      chk("role_hi", role_level, 16'h0001 << fn);
    end
    apb(1'b1, A_CTRL, 32'h00008401);
    repeat (3) @(posedge core_clk);
    chk("role_off", role_level, 16'h0000);
    // Edge modes, polarity and masking
    irq_case(16'h8481, 1'b1, 1'b0, 1'b1, 1'b1);
    irq_case(16'h8481, 1'b1, 1'b1, 1'b0, 1'b0);
    irq_case(16'h8081, 1'b1, 1'b1, 1'b0, 1'b1);
    irq_case(16'h8081, 1'b1, 1'b0, 1'b1, 1'b0);
    irq_case(16'h9481, 1'b1, 1'b1, 1'b0, 1'b1);
    irq_case(16'h9081, 1'b1, 1'b0, 1'b1, 1'b1);
    irq_case(16'h8481, 1'b0, 1'b0, 1'b1, 1'b1);
    wrap_up();
  end

  // Watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge core_clk);
    fails++;
    wrap_up();
  end
endmodule : testbench

`default_nettype wire
